// ==== common/ivc_pkg.sv ====
// shared constants and types of the i/o virtualization capability bank
package ivc_pkg;

  // ==========================================================================
  // access port geometry
  localparam int unsigned ADDR_W   = 12;          // byte offset in capability
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned VF_LIMIT = 63;          // most virtual functions
  localparam int unsigned SLOT_LIMIT = 255;       // most device slots
  localparam int unsigned INTR_LIMIT = 1024;      // most interrupters

  // ==========================================================================
  // register offsets, in 32-bit words from the capability base
  localparam logic [9:0] HDR_WORD     = 10'h000;  // capability header
  localparam logic [9:0] IR_FIRST     = 10'h001;  // range reg of function 1
  localparam logic [9:0] SLOT_SKIP    = 10'h001;  // word after the range regs

  // ==========================================================================
  // capability header fields
  localparam int unsigned HDR_ID_LSB   = 0;
  localparam int unsigned HDR_ID_W     = 8;
  localparam int unsigned HDR_NEXT_LSB = 8;
  localparam int unsigned HDR_NEXT_W   = 8;

  // ==========================================================================
  // interrupter range fields
  localparam int unsigned IR_BASE_LSB = 0;
  localparam int unsigned IR_CNT_LSB  = 10;
  localparam int unsigned IR_FIELD_W  = 10;
  localparam int unsigned IR_STORE_W  = 20;      // bits 31:20 read zero
  localparam logic [IR_STORE_W-1:0] IR_RESET = 20'h00000;

  // ==========================================================================
  // device slot assignment fields
  localparam int unsigned SLOT_OWNER_LSB = 0;
  localparam int unsigned SLOT_OWNER_W   = 8;
  localparam int unsigned SLOT_EMUL_BIT  = 8;
  localparam int unsigned SLOT_STORE_W   = 9;
  localparam logic [SLOT_STORE_W-1:0] SLOT_RESET = 9'h000;

  // ==========================================================================
  // access carriers
  typedef struct packed {
    logic              valid;
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } ivc_req_t;

  typedef struct packed {
    logic              ack;
    logic [DATA_W-1:0] rdata;
  } ivc_rsp_t;

endpackage

// ==== src/ivc_regs.sv ====
// register bank of the i/o virtualization extended capability
//
// Contract
// - one interrupter range register per supported virtual function.
// - hardware reset clears every interrupter range register to zero.
// - no interrupter range register exists at index zero.
// - at most 63 virtual functions are supported or advertised.
// - primary keeps maximum interrupters minus the sum of function counts.
// - one slot assignment register per slot, emulated bit and owner.
// - reset makes every slot owner zero, the primary function.
// - emulated bit records emulated versus direct assignment of the slot.
// - with virtualization, register sets sit on separate pages.
// - without virtualization, register sets may share one page.
// - one page size only; it sets offsets and window size.
// - supported page size advertises exactly the host page granule.
// - header bits 7:0 hold a read-only id; bits 31:16 reserved.
// - header bits 15:8 hold the read-only next capability pointer.
// - range registers are 32 bits, reset zero, at base plus 4 x index.
// - this structure coexists with the standard virtualization capability.
// - capability lives in memory space, linked in the capability chain.
`timescale 1ns/1ps
module ivc_regs #(
  parameter int unsigned NUM_VF       = 8,
  parameter int unsigned NUM_SLOTS    = 16,
  parameter int unsigned MAX_INTR     = 64,
  parameter logic [7:0]  CAP_ID       = 8'h0a,   // arbitrary value
  parameter logic [7:0]  NEXT_PTR     = 8'h00,   // end of chain by default
  parameter logic [15:0] PAGE_GRANULE = 16'h0001,
  parameter logic        VIRT_ON      = 1'b1
) (
  // clock and reset
  input  wire  logic                               clk,
  input  wire  logic                               nrst,
  // register access
  input  wire  ivc_pkg::ivc_req_t                  req,
  output       ivc_pkg::ivc_rsp_t                  rsp,
  // interrupter map towards the interrupter logic
  output logic [NUM_VF*ivc_pkg::IR_FIELD_W-1:0]    vfIntrBase,
  output logic [NUM_VF*ivc_pkg::IR_FIELD_W-1:0]    vfIntrCount,
  output logic [ivc_pkg::IR_FIELD_W:0]             pfIntrRemain,
  output logic                                     intrOversub,
  // slot ownership towards the slot logic
  output logic [NUM_SLOTS*ivc_pkg::SLOT_OWNER_W-1:0] slotOwner,
  output logic [NUM_SLOTS-1:0]                     slotEmulated,
  // page layout towards the address decoder
  output logic [15:0]                              hostPageGranule,
  output logic [15:0]                              supportedPageSize,
  output logic                                     pageSplit
);

  // ==========================================================================
  // elaboration checks
  // limit on virtual functions
  if (NUM_VF < 1 || NUM_VF > ivc_pkg::VF_LIMIT) begin : gen_bad_vf
    $error("virtual function total out of range");
  end
  if (NUM_SLOTS < 1 || NUM_SLOTS > ivc_pkg::SLOT_LIMIT) begin : gen_bad_slots
    $error("device slot count out of range");
  end
  if (MAX_INTR < 1 || MAX_INTR > ivc_pkg::INTR_LIMIT) begin : gen_bad_intr
    $error("interrupter count out of range");
  end
  // one page size only, so the granule must be a single bit
  if (PAGE_GRANULE == 16'h0000 ||
      (PAGE_GRANULE & (PAGE_GRANULE - 16'h0001)) != 16'h0000) begin : gen_pg
    $error("page granule must name exactly one size");
  end

  localparam int unsigned SUM_W = 17;            // room for 63 x 1023

  // ==========================================================================
  // decode helpers
  // word index within the capability, byte lanes dropped
  function automatic logic [9:0] wordOf(input logic [ivc_pkg::ADDR_W-1:0] a);
    return a[ivc_pkg::ADDR_W-1:2];
  endfunction

  // word just before the slot assignment array; slot 1 sits one word above
  localparam logic [9:0] SLOT_BASE =
    10'(ivc_pkg::SLOT_SKIP + NUM_VF);

  function automatic logic isRange(input logic [9:0] w);
    return (w >= ivc_pkg::IR_FIRST) && (w <= 10'(NUM_VF));
  endfunction

  function automatic logic isSlot(input logic [9:0] w);
    return (w > SLOT_BASE) && (w <= 10'(SLOT_BASE + NUM_SLOTS));
  endfunction

  // ==========================================================================
  // storage
  logic [ivc_pkg::IR_STORE_W-1:0]   irRange_r   [1:NUM_VF];
  logic [ivc_pkg::IR_STORE_W-1:0]   irRange_nxt [1:NUM_VF];
  logic [ivc_pkg::SLOT_STORE_W-1:0] slotReg_r   [1:NUM_SLOTS];
  logic [ivc_pkg::SLOT_STORE_W-1:0] slotReg_nxt [1:NUM_SLOTS];
  ivc_pkg::ivc_rsp_t                rsp_r;
  ivc_pkg::ivc_rsp_t                rsp_nxt;
  logic [9:0]                       reqWord;
  logic [31:0]                      headerWord;

  assign reqWord = wordOf(req.addr);

  assign headerWord = {16'h0000, NEXT_PTR, CAP_ID};

  // ==========================================================================
  // next-state of the register arrays
  // header is never a write target, so software cannot disturb it
  always_comb begin
    for (int v = 1; v <= NUM_VF; v++) begin
      irRange_nxt[v] = irRange_r[v];
    end
    for (int s = 1; s <= NUM_SLOTS; s++) begin
      slotReg_nxt[s] = slotReg_r[s];
    end
    if (req.valid && req.write) begin
      // range register at base plus four times index
      // one register per function, none at index 0
      for (int v = 1; v <= NUM_VF; v++) begin
        if (reqWord == 10'(v))
          irRange_nxt[v] = req.wdata[ivc_pkg::IR_STORE_W-1:0];
      end
      for (int s = 1; s <= NUM_SLOTS; s++) begin
        if (reqWord == 10'(SLOT_BASE + s))
          slotReg_nxt[s] = req.wdata[ivc_pkg::SLOT_STORE_W-1:0];
      end
    end
  end

  // every slot back to the primary function
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int v = 1; v <= NUM_VF; v++) begin
        irRange_r[v] <= ivc_pkg::IR_RESET;
      end
      for (int s = 1; s <= NUM_SLOTS; s++) begin
        slotReg_r[s] <= ivc_pkg::SLOT_RESET;
      end
    end else begin
      irRange_r <= irRange_nxt;
      slotReg_r <= slotReg_nxt;
    end
  end

  // ==========================================================================
  // read path; answer one cycle after every request, unmapped reads zero
  // memory-mapped access answered
  always_comb begin
    rsp_nxt.ack   = req.valid;
    rsp_nxt.rdata = 32'h00000000;
    if (req.valid && !req.write) begin
      if (reqWord == ivc_pkg::HDR_WORD)
        rsp_nxt.rdata = headerWord;
      for (int v = 1; v <= NUM_VF; v++) begin
        if (reqWord == 10'(v))
          rsp_nxt.rdata = {12'h000, irRange_r[v]};
      end
      for (int s = 1; s <= NUM_SLOTS; s++) begin
        if (reqWord == 10'(SLOT_BASE + s))
          rsp_nxt.rdata = {23'h000000, slotReg_r[s]};
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      rsp_r <= '0;
    else
      rsp_r <= rsp_nxt;
  end

  assign rsp = rsp_r;

  // ==========================================================================
  // field fan-out to the rest of the controller
  always_comb begin
    for (int v = 1; v <= NUM_VF; v++) begin
      vfIntrBase[(v-1)*ivc_pkg::IR_FIELD_W +: ivc_pkg::IR_FIELD_W] =
        irRange_r[v][ivc_pkg::IR_BASE_LSB +: ivc_pkg::IR_FIELD_W];
      vfIntrCount[(v-1)*ivc_pkg::IR_FIELD_W +: ivc_pkg::IR_FIELD_W] =
        irRange_r[v][ivc_pkg::IR_CNT_LSB +: ivc_pkg::IR_FIELD_W];
    end
    for (int s = 1; s <= NUM_SLOTS; s++) begin
      slotOwner[(s-1)*ivc_pkg::SLOT_OWNER_W +: ivc_pkg::SLOT_OWNER_W] =
        slotReg_r[s][ivc_pkg::SLOT_OWNER_LSB +: ivc_pkg::SLOT_OWNER_W];
      slotEmulated[s-1] = slotReg_r[s][ivc_pkg::SLOT_EMUL_BIT];
    end
  end

  // ==========================================================================
  // primary function share of the interrupters
  // total handed out; wide enough that it never wraps
  function automatic logic [SUM_W-1:0] countSum(
    input logic [NUM_VF*ivc_pkg::IR_FIELD_W-1:0] cnt);
    logic [SUM_W-1:0] acc;
    acc = '0;
    for (int v = 0; v < NUM_VF; v++) begin
      acc = acc + SUM_W'(cnt[v*ivc_pkg::IR_FIELD_W +: ivc_pkg::IR_FIELD_W]);
    end
    return acc;
  endfunction

  logic [SUM_W-1:0] grantedSum;
  assign grantedSum = countSum(vfIntrCount);

  // primary keeps the remainder
  // oversubscription is a software fault; the remainder then floors at zero
  // rather than wrapping into a huge bogus share
  always_comb begin
    intrOversub  = grantedSum > SUM_W'(MAX_INTR);
    pfIntrRemain = intrOversub ? '0 :
      (ivc_pkg::IR_FIELD_W+1)'(SUM_W'(MAX_INTR) - grantedSum);
  end

  // ==========================================================================
  // page layout
  // single page size drives offsets
  // size advert for the companion capability
  assign hostPageGranule   = PAGE_GRANULE;
  assign supportedPageSize = PAGE_GRANULE;
  assign pageSplit         = VIRT_ON;

  // ==========================================================================
  // checks
  logic firstCyc_r;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      firstCyc_r <= 1'b1;
    else
      firstCyc_r <= 1'b0;
  end

  sequence hdrWrite;
    req.valid && req.write && wordOf(req.addr) == ivc_pkg::HDR_WORD;
  endsequence

  sequence hdrRead;
    req.valid && !req.write && wordOf(req.addr) == ivc_pkg::HDR_WORD;
  endsequence

  sequence vf1Write;
    req.valid && req.write && wordOf(req.addr) == ivc_pkg::IR_FIRST;
  endsequence

  sequence slot1Write;
    req.valid && req.write && wordOf(req.addr) == 10'(SLOT_BASE + 1);
  endsequence

  sequence pastLastWrite;
    req.valid && req.write && wordOf(req.addr) == SLOT_BASE;
  endsequence

  sequence slotRead;
    req.valid && !req.write && isSlot(wordOf(req.addr));
  endsequence

  AST_ACK_ONE: assert property (@(posedge clk) disable iff (!nrst)
    req.valid |=> rsp.ack ##1 (rsp.ack == $past(req.valid)))
    else $error("access not answered in one cycle");

  AST_HDR_READ: assert property (@(posedge clk) disable iff (!nrst)
    hdrRead |=> rsp.rdata[7:0] == CAP_ID && rsp.rdata[15:8] == NEXT_PTR)
    else $error("header read wrong");

  AST_HDR_RO: assert property (@(posedge clk) disable iff (!nrst)
    hdrWrite ##1 hdrRead |=> rsp.rdata == {16'h0000, NEXT_PTR, CAP_ID})
    else $error("header changed by a write");

  AST_IR_WRITE: assert property (@(posedge clk) disable iff (!nrst)
    vf1Write |=> vfIntrCount[ivc_pkg::IR_FIELD_W-1:0] ==
      $past(req.wdata[19:10]) && vfIntrBase[ivc_pkg::IR_FIELD_W-1:0] ==
      $past(req.wdata[9:0]))
    else $error("range register did not take the write");

  AST_IR_HIGH_ZERO: assert property (@(posedge clk) disable iff (!nrst)
    req.valid && !req.write && isRange(wordOf(req.addr)) |=>
      rsp.rdata[31:20] == 12'h000)
    else $error("range register high bits not zero");

  AST_SLOT_WRITE: assert property (@(posedge clk) disable iff (!nrst)
    slot1Write |=> slotOwner[7:0] == $past(req.wdata[7:0]) &&
      slotEmulated[0] == $past(req.wdata[8]))
    else $error("slot register did not take the write");

  AST_RESET_CLEAR: assert property (@(posedge clk) disable iff (!nrst)
    firstCyc_r |-> vfIntrBase == '0 && vfIntrCount == '0 &&
      slotOwner == '0 && pfIntrRemain == (ivc_pkg::IR_FIELD_W+1)'(MAX_INTR))
    else $error("bank not clear after reset");

  AST_PF_SHARE: assert property (@(posedge clk) disable iff (!nrst)
    !intrOversub |-> SUM_W'(pfIntrRemain) + grantedSum == SUM_W'(MAX_INTR))
    else $error("primary share does not balance");

  AST_PAGE_ONE: assert property (@(posedge clk) disable iff (!nrst)
    supportedPageSize == hostPageGranule && $onehot(supportedPageSize))
    else $error("advertised page size differs");

  AST_UNMAPPED: assert property (@(posedge clk) disable iff (!nrst)
    req.valid && !req.write && wordOf(req.addr) != ivc_pkg::HDR_WORD &&
      !isRange(wordOf(req.addr)) && !isSlot(wordOf(req.addr)) |=>
      rsp.rdata == 32'h00000000)
    else $error("unmapped read not zero");

  AST_HDR_NO_RANGE: assert property (@(posedge clk) disable iff (!nrst)
    hdrWrite |=> $stable(vfIntrCount) && $stable(vfIntrBase))
    else $error("header write reached a range register");

  AST_PAST_LAST: assert property (@(posedge clk) disable iff (!nrst)
    pastLastWrite |=> $stable(vfIntrCount) && $stable(vfIntrBase) &&
      $stable(slotOwner) && $stable(slotEmulated))
    else $error("write past the last function changed the bank");

  AST_SLOT_HIGH_ZERO: assert property (@(posedge clk) disable iff (!nrst)
    slotRead |=> rsp.rdata[31:9] == 23'h000000)
    else $error("slot register high bits not zero");

  AST_WRITE_QUIET: assert property (@(posedge clk) disable iff (!nrst)
    req.valid && req.write |=> rsp.rdata == 32'h00000000)
    else $error("write answered with data");

  AST_SLOT_RESET: assert property (@(posedge clk) disable iff (!nrst)
    firstCyc_r |-> slotOwner == '0 && slotEmulated == '0)
    else $error("slot not back with the primary after reset");

  AST_OVERSUB_FLOOR: assert property (@(posedge clk) disable iff (!nrst)
    intrOversub |-> pfIntrRemain == '0)
    else $error("oversubscribed share did not floor at zero");

  AST_IR_READ: assert property (@(posedge clk) disable iff (!nrst)
    req.valid && !req.write && wordOf(req.addr) == ivc_pkg::IR_FIRST |=>
      rsp.rdata[19:10] == $past(vfIntrCount[ivc_pkg::IR_FIELD_W-1:0]) &&
      rsp.rdata[9:0] == $past(vfIntrBase[ivc_pkg::IR_FIELD_W-1:0]))
    else $error("range register read wrong");

endmodule

// ==== verif/ivc_regs_test.sv ====
// self-checking testbench of the i/o virtualization capability bank
`timescale 1ns/1ps
module ivc_regs_test;

  // ==========================================================================
  // build parameters and bench state
  localparam int unsigned NVF   = 8;
  localparam int unsigned NSL   = 16;
  localparam int unsigned MI    = 64;
  localparam logic [7:0]  CID   = 8'h5c;     // arbitrary identifier value
  localparam logic [7:0]  NXT   = 8'h40;
  localparam logic [15:0] PG    = 16'h0002;
  localparam int          LIMIT = 3000;      // generous over ~175 used

  logic                              clk;
  logic                              nrst;
  ivc_pkg::ivc_req_t                 req;
  ivc_pkg::ivc_rsp_t                 rsp;
  logic [NVF*ivc_pkg::IR_FIELD_W-1:0] vfIntrBase;
  logic [NVF*ivc_pkg::IR_FIELD_W-1:0] vfIntrCount;
  logic [ivc_pkg::IR_FIELD_W:0]      pfIntrRemain;
  logic                              intrOversub;
  logic [NSL*8-1:0]                  slotOwner;
  logic [NSL-1:0]                    slotEmulated;
  logic [15:0]                       hostPageGranule;
  logic [15:0]                       supportedPageSize;
  logic                              pageSplit;
  int                                numErrors;
  int                                totalChecks;
  int                                cycles;
  logic [31:0]                       rd;

  ivc_regs #(
    .NUM_VF       (NVF),
    .NUM_SLOTS    (NSL),
    .MAX_INTR     (MI),
    .CAP_ID       (CID),
    .NEXT_PTR     (NXT),
    .PAGE_GRANULE (PG),
    .VIRT_ON      (1'b1)
  ) i_ivc_regs (
    .clk               (clk),
    .nrst              (nrst),
    .req               (req),
    .rsp               (rsp),
    .vfIntrBase        (vfIntrBase),
    .vfIntrCount       (vfIntrCount),
    .pfIntrRemain      (pfIntrRemain),
    .intrOversub       (intrOversub),
    .slotOwner         (slotOwner),
    .slotEmulated      (slotEmulated),
    .hostPageGranule   (hostPageGranule),
    .supportedPageSize (supportedPageSize),
    .pageSplit         (pageSplit)
  );

  // ==========================================================================
  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // a stuck access would otherwise spin forever
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      numErrors++;
      testDone();
    end
  end

  // ==========================================================================
  // helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      numErrors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic logic [11:0] slotAddr(input int s);
    return 12'(4 * (1 + NVF) + 4 * s);
  endfunction

  // one access: request held until the taking edge, ack seen just after it
  task automatic access(input logic wr, input logic [11:0] a,
                        input logic [31:0] d);
    @(posedge clk);
    req <= '{valid: 1'b1, write: wr, addr: a, wdata: d};
    @(posedge clk);
    req.valid <= 1'b0;
    #1;
    check({31'h0, rsp.ack}, 32'h1);
    rd = rsp.rdata;
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    access(1'b0, a, 32'h0);
    check(rd, exp);
  endtask

  // write then read in the very next cycle, no idle cycle between them
  task automatic wrRd(input logic [11:0] a, input logic [31:0] d,
                      input logic [31:0] exp);
    @(posedge clk);
    req <= '{valid: 1'b1, write: 1'b1, addr: a, wdata: d};
    @(posedge clk);
    req <= '{valid: 1'b1, write: 1'b0, addr: a, wdata: 32'h0};
    #1;
    check({31'h0, rsp.ack}, 32'h1);
    @(posedge clk);
    req.valid <= 1'b0;
    #1;
    check({31'h0, rsp.ack}, 32'h1);
    check(rsp.rdata, exp);
  endtask

  task automatic testDone();
    $display("checks %0d errors %0d", totalChecks, numErrors);
    if (numErrors == 0 && totalChecks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    nrst = 1'b0;
    req = '0;
    numErrors = 0;
    totalChecks = 0;
    cycles = 0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    // reset contents and fixed layout outputs
    rdchk(12'h000, {16'h0, NXT, CID});
    for (int v = 1; v <= NVF; v++) begin
      rdchk(12'(4 * v), 32'h0);
    end
    for (int s = 1; s <= NSL; s++) begin
      rdchk(slotAddr(s), 32'h0);
    end
    check({21'h0, pfIntrRemain}, 32'(MI));
    check({31'h0, intrOversub}, 32'h0);
    // software would program the companion page size from this granule
    check({16'h0, hostPageGranule}, {16'h0, PG});
    check({16'h0, supportedPageSize}, {16'h0, PG});
    check({31'h0, pageSplit}, 32'h1);
    // header is read only, reserved bits stay zero
    access(1'b1, 12'h000, 32'hffffffff);
    rdchk(12'h000, {16'h0, NXT, CID});
    wrRd(12'h000, 32'hffffffff, {16'h0, NXT, CID});
    // function v gets count v at base 4v; upper bits written as ones
    // bases start at 4, interrupter 0 stays with the primary
    for (int v = 1; v <= NVF; v++) begin
      access(1'b1, 12'(4 * v), {12'hfff, 10'(v), 10'(4 * v)});
    end
    for (int v = 1; v <= NVF; v++) begin
      rdchk(12'(4 * v), {12'h0, 10'(v), 10'(4 * v)});
      check(32'(vfIntrCount[(v-1)*10 +: 10]), 32'(v));
      check(32'(vfIntrBase[(v-1)*10 +: 10]), 32'(4 * v));
    end
    check({21'h0, pfIntrRemain}, 32'(MI - 36));
    // no range register past the last function, nothing past last slot
    access(1'b1, 12'(4 * (NVF + 1)), 32'hffffffff);
    rdchk(12'(4 * (NVF + 1)), 32'h0);
    rdchk(slotAddr(NSL + 1), 32'h0);
    // oversubscribe: 60 + (2..8) exceeds the pool
    access(1'b1, 12'h004, {12'h0, 10'd60, 10'd4});
    check({31'h0, intrOversub}, 32'h1);
    check({21'h0, pfIntrRemain}, 32'h0);
    // slots: owner s, emulated on odd slots
    for (int s = 1; s <= NSL; s++) begin
      access(1'b1, slotAddr(s), {23'h7fffff, 1'(s), 8'(s)});
      rdchk(slotAddr(s), {23'h0, 1'(s), 8'(s)});
      check(32'(slotOwner[(s-1)*8 +: 8]), 32'(s));
      check({31'h0, slotEmulated[s-1]}, {31'h0, 1'(s)});
    end
    // back to back: the read in the next cycle sees the fresh value
    wrRd(12'h008, 32'h00000c07, 32'h00000c07);
    // second reset in mid-run clears every range and slot register
    @(posedge clk);
    nrst <= 1'b0;
    @(posedge clk);
    nrst <= 1'b1;
    #1;
    check({31'h0, vfIntrCount == '0}, 32'h1);
    check({31'h0, vfIntrBase == '0}, 32'h1);
    check({31'h0, slotOwner == '0}, 32'h1);
    check({31'h0, slotEmulated == '0}, 32'h1);
    check({31'h0, intrOversub}, 32'h0);
    check({21'h0, pfIntrRemain}, 32'(MI));
    rdchk(12'h004, 32'h0);
    rdchk(slotAddr(NSL), 32'h0);
    testDone();
  end

endmodule
